//--- lss_pkg.sv
// constants and types for the linear sensor scan timing generator
// Function
// - one pixel out per sensor clock cycle
// - integration equals start high plus 48 clocks
// - shifting starts first clock rise after fall
// - first valid pixel on 89th strobe pulse
// - all pixels share one exposure window
// - dedicated strobe output marks sample moments
package lss_pkg;
	localparam int LSS_PIX_W = 12;
	localparam int LSS_CNT_W = 12;
	localparam int LSS_FIFO_DEPTH = 8;
	// sensor clock limits, for the controller side
	localparam int LSS_CLK_MIN_HZ = 200000;
	localparam int LSS_CLK_MAX_HZ = 10000000;
	localparam int LSS_SYS_CLK_HZ = 25000000;
	// start pulse limits in sensor clock periods, kept by the controller
	localparam int LSS_START_PERIOD_MIN = 106;
	localparam int LSS_START_HIGH_MIN = 6;
	localparam int LSS_START_LOW_MIN = 100;
	localparam int LSS_FULL_SCAN_PERIOD = 2140;
	// readout counts in sensor clock pulses
	localparam logic [LSS_CNT_W-1:0] LSS_PIX_COUNT = 12'h800;
	localparam logic [LSS_CNT_W-1:0] LSS_FIRST_PULSE = 12'h059;
	localparam logic [LSS_CNT_W-1:0] LSS_LAST_PULSE = LSS_FIRST_PULSE + LSS_PIX_COUNT - 12'h001;
	localparam logic [LSS_CNT_W-1:0] LSS_INTEG_EXTRA = 12'h030;
	localparam logic [LSS_CNT_W-1:0] LSS_INTEG_END = LSS_INTEG_EXTRA + 12'h001;
	localparam logic [LSS_CNT_W-1:0] LSS_CNT_RESET = 12'h000;
	localparam logic [LSS_PIX_W-1:0] LSS_LEVEL_RESET = 12'h000;

	typedef enum {
		LSS_IDLE,
		LSS_START_HIGH,
		LSS_READOUT
	} lss_state_t;

	typedef struct packed {
		logic valid;
		logic [LSS_PIX_W-1:0] level;
	} lss_video_t;
endpackage : lss_pkg

//--- lss_fifo.sv
// small pixel buffer with valid and ready on both sides
`timescale 1ns/1ns
module lss_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (count_q != '0);
	assign out_data = mem[rd_q];

	always_comb
	begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			count_q <= count_d;
			in_ready <= (count_d != FULL);
		end
	end
endmodule : lss_fifo

//--- lss_scan_timing.sv
// timing generator and video readout of the linear sensor
`timescale 1ns/1ns
module lss_scan_timing (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// controller pins
	input wire logic scan_start_pulse,
	input wire logic sensor_clk,
	// pixel levels from the photosite array
	input wire logic [lss_pkg::LSS_PIX_W-1:0] pix_level,
	input wire logic pix_valid,
	output logic pix_ready,
	// sensor outputs
	output lss_pkg::lss_video_t video_q,
	output logic trig_q,
	output logic integrating_q,
	output logic scan_valid_q
);
	import lss_pkg::*;

	function automatic logic lss_rise(input logic prev, input logic cur);
		lss_rise = cur && !prev;
	endfunction : lss_rise

	function automatic logic lss_fall(input logic prev, input logic cur);
		lss_fall = prev && !cur;
	endfunction : lss_fall

	// pulse numbers whose following pulse samples a pixel
	function automatic logic lss_in_window(input logic [LSS_CNT_W-1:0] pulse);
		lss_in_window = (pulse >= LSS_FIRST_PULSE - 12'h001) && (pulse < LSS_LAST_PULSE);
	endfunction : lss_in_window

	function automatic logic [LSS_CNT_W-1:0] lss_next_pulse(input logic [LSS_CNT_W-1:0] pulse);
		lss_next_pulse = pulse + 12'h001;
	endfunction : lss_next_pulse

	// state and pulse count
	lss_state_t state_q;
	lss_state_t state_d;
	logic clk_prev_q;
	logic clk_rise;
	logic clk_fall;
	logic [LSS_CNT_W-1:0] pulse_q;
	logic [LSS_CNT_W-1:0] pulse_d;
	logic first_done_q;

	// pixel buffer side
	logic fifo_valid;
	logic [LSS_PIX_W-1:0] fifo_data;
	logic fifo_pop;
	logic in_window;
	logic fifo_in_ready;
	lss_video_t video_d;

	// decoded strobes
	logic rd_begin;
	logic rd_end;
	logic integ_open;
	logic integ_close;

	// edges of the controller's clock, sampled on sys_clk
	assign clk_rise = lss_rise(clk_prev_q, sensor_clk);
	assign clk_fall = lss_fall(clk_prev_q, sensor_clk);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			clk_prev_q <= 1'b0;
		else
			clk_prev_q <= sensor_clk;
	end

	assign in_window = lss_in_window(pulse_q);
	assign fifo_pop = (state_q == LSS_READOUT) && clk_fall && in_window;

	// scan boundaries and exposure edges, all on sensor clock rises
	assign rd_begin = clk_rise && state_q == LSS_START_HIGH && state_d == LSS_READOUT;
	assign rd_end = clk_rise && state_q == LSS_READOUT && state_d == LSS_IDLE;
	assign integ_open = clk_rise && state_d == LSS_START_HIGH;
	assign integ_close = clk_rise && state_d == LSS_READOUT && pulse_d == LSS_INTEG_END;

	lss_fifo #(
		.WIDTH(LSS_PIX_W),
		.DEPTH(LSS_FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(pix_valid),
		.in_data(pix_level),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(fifo_pop)
	);

	assign pix_ready = fifo_in_ready;

	// scan sequencing on sensor clock rising edges
	always_comb
	begin
		state_d = state_q;
		pulse_d = pulse_q;
		if (clk_rise)
		begin
			case (state_q)
				LSS_IDLE:
				begin
					if (scan_start_pulse)
						state_d = LSS_START_HIGH;
				end
				LSS_START_HIGH:
				begin
					if (!scan_start_pulse)
					begin
						state_d = LSS_READOUT;
						pulse_d = 12'h001;
					end
				end
				LSS_READOUT:
				begin
					if (scan_start_pulse)
					begin
						// a new start aborts the current readout
						state_d = LSS_START_HIGH;
						pulse_d = LSS_CNT_RESET;
					end
					else if (pulse_q == LSS_LAST_PULSE)
					begin
						state_d = LSS_IDLE;
						pulse_d = LSS_CNT_RESET;
					end
					else
						pulse_d = lss_next_pulse(pulse_q);
				end
				default:
				begin
					state_d = LSS_IDLE;
					pulse_d = LSS_CNT_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			state_q <= LSS_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			pulse_q <= LSS_CNT_RESET;
		else
			pulse_q <= pulse_d;
	end

	// strobe follows the sensor clock during readout, one pulse per clock from pulse 1, pixels from pulse 89
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			trig_q <= 1'b0;
		else
			trig_q <= sensor_clk && (state_d == LSS_READOUT);
	end

	// one shared exposure window for the whole line
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			integrating_q <= 1'b0;
		else if (integ_open)
			integrating_q <= 1'b1;
		else if (integ_close)
			integrating_q <= 1'b0;
	end

	// video changes on the clock fall, stable at the next strobe rise
	always_comb
	begin
		video_d = video_q;
		if (fifo_pop)
		begin
			video_d.valid = fifo_valid;
			video_d.level = fifo_valid ? fifo_data : LSS_LEVEL_RESET;
		end
		else if (state_q != LSS_READOUT || (clk_fall && !in_window))
		begin
			video_d.valid = 1'b0;
			video_d.level = LSS_LEVEL_RESET;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			video_q.valid <= 1'b0;
			video_q.level <= LSS_LEVEL_RESET;
		end
		else
			video_q <= video_d;
	end

	// first complete scan after reset is flagged as not usable
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			first_done_q <= 1'b0;
		else if (rd_end)
			first_done_q <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			scan_valid_q <= 1'b0;
		else if (rd_begin)
			scan_valid_q <= first_done_q;
	end
endmodule : lss_scan_timing

//--- lss_scan_timing_monitor.sv
// assertions on the scan timing block ports
`timescale 1ns/1ns
module lss_scan_timing_monitor
	import lss_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// pins
	input wire logic scan_start_pulse,
	input wire logic sensor_clk,
	input wire lss_pkg::lss_video_t video_q,
	input wire logic trig_q,
	input wire logic integrating_q
);
	logic [11:0] pcnt_q;
	logic [7:0] icnt_q;
	logic trig_d1_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// strobe pulses since the start pin was last high
	always_ff @(posedge sys_clk)
	begin
		trig_d1_q <= trig_q;
		if (reset || scan_start_pulse)
			pcnt_q <= 12'h000;
		else if (trig_q && !trig_d1_q)
			pcnt_q <= pcnt_q + 12'h001;
	end
	// strobe pulses inside the exposure window
	always_ff @(posedge sys_clk)
	begin
		if (reset || !integrating_q)
			icnt_q <= 8'h00;
		else if (trig_q && !trig_d1_q)
			icnt_q <= icnt_q + 8'h01;
	end
	AST_TRIG_RISE: assert property ($rose(trig_q) |-> $past(sensor_clk) && !$past(sensor_clk, 2))
	else $error("strobe rise not after clock rise");
	AST_TRIG_FALL: assert property (trig_q && !sensor_clk |=> !trig_q)
	else $error("strobe held past clock fall");
	AST_READ_START: assert property ($rose(trig_q) |-> !$past(scan_start_pulse))
	else $error("strobe while start high");
	AST_INTEG_SET: assert property (sensor_clk && !$past(sensor_clk) && scan_start_pulse |=> integrating_q)
	else $error("exposure not opened");
	AST_INTEG_LEN: assert property ($fell(integrating_q) |-> icnt_q == 8'h30 && $rose(trig_q))
	else $error("exposure length wrong");
	AST_VIDEO_FIRST: assert property ($rose(video_q.valid) |-> pcnt_q == 12'h058)
	else $error("first pixel misplaced");
	AST_VIDEO_WIN: assert property (video_q.valid |-> pcnt_q >= 12'h058 && pcnt_q <= 12'h858)
	else $error("pixel outside window");
	AST_TRIG_STOP: assert property ($rose(trig_q) |-> pcnt_q < 12'h858)
	else $error("strobe after last pixel");
	AST_VIDEO_HOLD: assert property (!$stable(video_q) |-> !$past(sensor_clk) && $past(sensor_clk, 2))
	else $error("video changed off a clock fall");
endmodule : lss_scan_timing_monitor
bind lss_scan_timing lss_scan_timing_monitor u_mon (.sys_clk, .reset, .scan_start_pulse,
	.sensor_clk, .video_q, .trig_q, .integrating_q);

//--- lss_ctrl_model.sv
// controller model: start pulse, sensor clock and video sampling
`timescale 1ns/1ns
module lss_ctrl_model
	import lss_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// sensor pins
	output logic scan_start_pulse,
	output logic sensor_clk,
	input wire logic trig_q,
	input wire lss_pkg::lss_video_t video_q,
	// samples
	output logic smp_ok,
	output logic [lss_pkg::LSS_PIX_W-1:0] smp
);
	int n_trig;
	logic trig_d;
	initial
	begin
		scan_start_pulse = 1'b0;
		sensor_clk = 1'b0;
		trig_d = 1'b0;
		smp_ok = 1'b0;
	end
	// one clock of 4 sys cycles, start changed while low
	task automatic tick(input logic st);
		@(posedge sys_clk) #1 sensor_clk = 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk) #1 sensor_clk = 1'b0;
		scan_start_pulse = st;
		@(posedge sys_clk);
	endtask : tick
	task automatic scan(input int hi);
		repeat (hi) tick(1'b1);
		repeat (LSS_FULL_SCAN_PERIOD - hi) tick(1'b0);
	endtask : scan
	always @(posedge sys_clk)
	begin
		smp_ok <= 1'b0;
		trig_d <= trig_q;
		if (scan_start_pulse)
			n_trig <= 0;
		else if (trig_q && !trig_d)
		begin
			n_trig <= n_trig + 1;
			if (n_trig >= 88 && video_q.valid)
			begin
				smp_ok <= 1'b1;
				smp <= video_q.level;
			end
		end
	end
endmodule : lss_ctrl_model

//--- lss_scan_timing_tb.sv
// self-checking bench for the scan timing block
`timescale 1ns/1ns
module lss_scan_timing_tb;
	import lss_pkg::*;
	logic sys_clk, reset, pix_valid, pix_ready, scan_start_pulse, sensor_clk;
	logic trig_q, integrating_q, scan_valid_q, smp_ok, src_on, sv_exp, tk;
	logic [LSS_PIX_W-1:0] pix_level, smp;
	logic [LSS_PIX_W-1:0] q[$];
	lss_video_t video_q;
	int n_fail, check_count, nv, ni, hi, ne;
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	lss_scan_timing u_lss_scan_timing (.sys_clk, .reset, .scan_start_pulse, .sensor_clk,
		.pix_level, .pix_valid, .pix_ready, .video_q, .trig_q, .integrating_q, .scan_valid_q);
	lss_ctrl_model u_lss_ctrl_model (.sys_clk, .scan_start_pulse, .sensor_clk, .trig_q,
		.video_q, .smp_ok, .smp);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// pixel source with random stalls, data held until taken
	always @(posedge sys_clk)
	begin
		tk = pix_valid === 1'b1 && pix_ready === 1'b1;
		if (tk)
			q.push_back(pix_level);
		#1;
		if (tk || !pix_valid)
		begin
			pix_level = 12'($urandom);
			pix_valid = src_on && ($urandom % 4 != 0);
		end
	end
	always @(posedge sys_clk)
	begin
		if (smp_ok)
		begin
			nv++;
			chk(smp, q.pop_front());
			chk(scan_valid_q, sv_exp);
		end
		if (integrating_q === 1'b1)
			ni++;
	end
	initial
	begin
		void'($urandom(62));
		reset = 1'b1;
		pix_valid = 1'b0;
		pix_level = 12'h000;
		src_on = 1'b1;
		sv_exp = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 reset = 1'b0;
		// fill the buffer until it refuses
		for (int i = 0; i < 60 && pix_ready !== 1'b0; i++)
			@(posedge sys_clk);
		chk(pix_ready, 1'b0);
		// last scan drains the buffer with the source off
		for (int s = 0; s < 3; s++)
		begin
			@(negedge sys_clk);
			hi = (s == 0) ? 6 : 6 + $urandom % 32;
			src_on = (s < 2);
			ne = (s < 2) ? 2048 : q.size() + (pix_valid === 1'b1);
			nv = 0;
			ni = 0;
			u_lss_ctrl_model.scan(hi);
			repeat (10) u_lss_ctrl_model.tick(1'b0);
			chk(nv, ne);
			chk(ni, (hi + 48) * 4);
			sv_exp = 1'b1;
		end
		summarize();
	end
	initial
	begin
		#2000000;
		n_fail++;
		summarize();
	end
endmodule : lss_scan_timing_tb
